//--- common/thermal_pkg.sv
// Operation
// - sensor enable bit 14, reset one
// - armed and enabled overheat cuts speakers
// - overheat means about 150 C threshold
// - temp-ok readable, on pin, interrupt source
package thermal_pkg;
  localparam logic [7:0] PWR_ONE_ADDR = 8'h01;   // power_control_one
  localparam logic [7:0] PWR_TWO_ADDR = 8'h02;   // power_control_two
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h20;  // sticky event status
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h21;  // interrupt mask
  localparam logic [7:0] PIN_SEL_ADDR = 8'h22;   // pin one routing
  localparam logic [15:0] PWR_ONE_RST = 16'h0000;
  localparam logic [15:0] PWR_TWO_RST = 16'h6000;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam int SENSE_ENA_BIT = 14;             // sensor enable
  localparam int CUT_ARM_BIT = 13;               // overheat_output_cut
  localparam int SPK_RIGHT_BIT = 13;             // speaker_right_on
  localparam int SPK_LEFT_BIT = 12;              // speaker_left_on
  localparam int EV_FALL_BIT = 0;                // temp-ok lost
  localparam int EV_RISE_BIT = 1;                // temp-ok regained
  localparam logic [1:0] EV_ZERO = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h3;        // all masked after reset
  localparam int TRIP_CELSIUS = 150;             // nominal trip point

  // pin one routing choices
  typedef enum logic [1:0] {
    PIN_LOW = 2'b00,
    PIN_TEMP_OK = 2'b01,
    PIN_IRQ = 2'b10,
    PIN_HIGH = 2'b11
  } pin_sel_e;

  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;
endpackage

//--- logic/thermal_shutdown_control.sv
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module thermal_shutdown_control
  import thermal_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire bus_req_s busReq,
  output logic [15:0] readData,
  // analog sensor comparator: high while die below trip point
  input wire logic sensorTempOk,
  // outputs
  output logic speakerLeftOut,
  output logic speakerRightOut,
  output logic generalPinOne,
  output logic irqOut
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [15:0] pwrOne_r, pwrOne_nxt;       // power_control_one
  logic [15:0] pwrTwo_r, pwrTwo_nxt;       // power_control_two
  logic [1:0] irqStat_r, irqStat_nxt;      // sticky events
  logic [1:0] irqMask_r, irqMask_nxt;      // 1 = masked
  pin_sel_e pinSel_r, pinSel_nxt;          // pin one source
  logic tempOk_r, tempOk_nxt;              // registered flag
  // bit of the live flag in the status read word
  localparam int LIVE_FLAG_BIT = 2;
  // next values of the registered outputs
  logic [15:0] readData_nxt;
  logic spkL_nxt, spkR_nxt, pin_nxt, irq_nxt;
  logic cutActive;                         // overheat cut in force
  logic [1:0] events;                      // edges of temp-ok

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  // register holds, writes, event edges and read mux in one pass
  always_comb begin
    // default: control registers keep their value, read data returns to zero
    pwrOne_nxt = pwrOne_r;
    pwrTwo_nxt = pwrTwo_r;
    irqMask_nxt = irqMask_r;
    pinSel_nxt = pinSel_r;
    readData_nxt = ZERO16;
    // flag sampled only while sensor is enabled; off sensor reads ok
    tempOk_nxt = pwrTwo_r[SENSE_ENA_BIT] ? sensorTempOk : 1'b1;
    // edges between the held flag and its next value
    events = EV_ZERO;
    events[EV_FALL_BIT] = tempOk_r & ~tempOk_nxt;
    events[EV_RISE_BIT] = ~tempOk_r & tempOk_nxt;
    // status starts from its held value
    irqStat_nxt = irqStat_r;
    // register writes
    if (busReq.wr) begin
      case (busReq.addr)
        PWR_ONE_ADDR: pwrOne_nxt = busReq.wdata;
        PWR_TWO_ADDR: pwrTwo_nxt = busReq.wdata;
        // a one written clears that status bit
        IRQ_STAT_ADDR: irqStat_nxt = irqStat_r & ~busReq.wdata[1:0];
        IRQ_MASK_ADDR: irqMask_nxt = busReq.wdata[1:0];
        // pin one source, every code is legal
        PIN_SEL_ADDR: pinSel_nxt = pin_sel_e'(busReq.wdata[1:0]);
        default: ;                       // unmapped write ignored
      endcase
    end
    // set wins over clear
    irqStat_nxt = irqStat_nxt | events;
    // register reads, data one cycle later
    if (busReq.rd) begin
      case (busReq.addr)
        PWR_ONE_ADDR: readData_nxt = pwrOne_r;
        PWR_TWO_ADDR: readData_nxt = pwrTwo_r;
        // live flag beside the sticky events
        IRQ_STAT_ADDR: readData_nxt = {12'h000, 1'b0, tempOk_r, irqStat_r};
        IRQ_MASK_ADDR: readData_nxt = {14'h0000, irqMask_r};
        PIN_SEL_ADDR: readData_nxt = {14'h0000, pinSel_r};
        default: readData_nxt = ZERO16;  // unmapped reads zero
      endcase
    end
  end

  // cut needs both enable and arm, holds while flag low
  assign cutActive = pwrTwo_r[SENSE_ENA_BIT] & pwrTwo_r[CUT_ARM_BIT] & ~tempOk_r;

  ////////////////////////////////////////////////////////////////////////////
  // output next values
  always_comb begin
    // speakers follow their enables unless cut
    spkL_nxt = pwrOne_r[SPK_LEFT_BIT] & ~cutActive;
    spkR_nxt = pwrOne_r[SPK_RIGHT_BIT] & ~cutActive;
    // interrupt level from unmasked events
    irq_nxt = |(irqStat_r & ~irqMask_r);
    // pin one source select
    case (pinSel_r)
      PIN_LOW: pin_nxt = 1'b0;
      PIN_TEMP_OK: pin_nxt = tempOk_r;
      PIN_IRQ: pin_nxt = |(irqStat_r & ~irqMask_r);
      PIN_HIGH: pin_nxt = 1'b1;
      default: pin_nxt = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      // reset values, all outputs low
      pwrOne_r <= PWR_ONE_RST;
      pwrTwo_r <= PWR_TWO_RST;
      irqStat_r <= EV_ZERO;
      irqMask_r <= MASK_RST;
      pinSel_r <= PIN_LOW;
      tempOk_r <= 1'b1;
      readData <= ZERO16;
      speakerLeftOut <= 1'b0;
      speakerRightOut <= 1'b0;
      generalPinOne <= 1'b0;
      irqOut <= 1'b0;
    end else begin
      // normal update from next values
      pwrOne_r <= pwrOne_nxt;
      pwrTwo_r <= pwrTwo_nxt;
      irqStat_r <= irqStat_nxt;
      irqMask_r <= irqMask_nxt;
      pinSel_r <= pinSel_nxt;
      tempOk_r <= tempOk_nxt;
      readData <= readData_nxt;
      speakerLeftOut <= spkL_nxt;
      speakerRightOut <= spkR_nxt;
      generalPinOne <= pin_nxt;
      irqOut <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_overheat;
    pwrTwo_r[SENSE_ENA_BIT] && pwrTwo_r[CUT_ARM_BIT] && !tempOk_r;
  endsequence

  a_cut_speakers: assert property (@(posedge mclk) disable iff (!reset_n)
    s_overheat |=> !speakerLeftOut && !speakerRightOut)
    else $error("speakers not cut on overheat");

  a_no_cut_disabled: assert property (@(posedge mclk) disable iff (!reset_n)
    !pwrTwo_r[SENSE_ENA_BIT] |=> speakerLeftOut == $past(pwrOne_r[SPK_LEFT_BIT]))
    else $error("cut without sensor enable");

  a_release_cut: assert property (@(posedge mclk) disable iff (!reset_n)
    tempOk_r && pwrOne_r[SPK_RIGHT_BIT] |=> speakerRightOut)
    else $error("speaker not released");

  a_sense_default: assert property (@(posedge mclk)
    $rose(reset_n) |-> pwrTwo_r[SENSE_ENA_BIT] && pwrTwo_r[CUT_ARM_BIT])
    else $error("enable reset value wrong");

  a_flag_track: assert property (@(posedge mclk) disable iff (!reset_n)
    pwrTwo_r[SENSE_ENA_BIT] |=> tempOk_r == $past(sensorTempOk))
    else $error("flag does not follow sensor");

  a_fall_event: assert property (@(posedge mclk) disable iff (!reset_n)
    $fell(tempOk_r) |-> irqStat_r[EV_FALL_BIT])
    else $error("fall event lost");

  a_pin_route: assert property (@(posedge mclk) disable iff (!reset_n)
    pinSel_r == PIN_TEMP_OK ##1 pinSel_r == PIN_TEMP_OK |-> generalPinOne == $past(tempOk_r))
    else $error("pin not routing flag");

  a_irq_level: assert property (@(posedge mclk) disable iff (!reset_n)
    ##1 irqOut == $past(|(irqStat_r & ~irqMask_r)))
    else $error("interrupt output wrong");

  // further checks on the cut, flag, events and bus
  // overheat seen on two edges in a row
  sequence s_hot_run;
    s_overheat [*2];
  endsequence

  a_cut_holds: assert property (@(posedge mclk) disable iff (!reset_n)
    s_hot_run |=> !speakerLeftOut && !speakerRightOut)
    else $error("cut not held while overheat");

  // a write to the second control register lands on the next edge
  a_ctl_write: assert property (@(posedge mclk) disable iff (!reset_n)
    busReq.wr && busReq.addr == PWR_TWO_ADDR |=> pwrTwo_r == $past(busReq.wdata))
    else $error("control write lost");

  // sensor off forces the flag to read ok
  a_off_reads_ok: assert property (@(posedge mclk) disable iff (!reset_n)
    !pwrTwo_r[SENSE_ENA_BIT] |=> tempOk_r)
    else $error("flag low with sensor off");

  // arm without enable leaves the right speaker alone
  a_arm_alone: assert property (@(posedge mclk) disable iff (!reset_n)
    !pwrTwo_r[SENSE_ENA_BIT] |=> speakerRightOut == $past(pwrOne_r[SPK_RIGHT_BIT]))
    else $error("right cut without sensor enable");

  // enable without arm never cuts
  a_enable_alone: assert property (@(posedge mclk) disable iff (!reset_n)
    !pwrTwo_r[CUT_ARM_BIT] |=> speakerLeftOut == $past(pwrOne_r[SPK_LEFT_BIT]))
    else $error("cut without arm");

  // rising flag raises its sticky event
  a_rise_event: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(tempOk_r) |-> irqStat_r[EV_RISE_BIT])
    else $error("rise event lost");

  // status read returns the live flag one cycle later
  a_flag_read: assert property (@(posedge mclk) disable iff (!reset_n)
    busReq.rd && busReq.addr == IRQ_STAT_ADDR |=> readData[LIVE_FLAG_BIT] == $past(tempOk_r))
    else $error("flag not readable");

  // sticky event stays until software clears it
  a_stat_sticky: assert property (@(posedge mclk) disable iff (!reset_n)
    !busReq.wr && irqStat_r[EV_FALL_BIT] |=> irqStat_r[EV_FALL_BIT])
    else $error("event lost without clear");

  // read data stands one cycle only
  a_read_one: assert property (@(posedge mclk) disable iff (!reset_n)
    !busReq.rd |=> readData == ZERO16)
    else $error("read data left standing");
endmodule

//--- tb/thermal_shutdown_control_tb.sv
`timescale 1ns/1ps
module thermal_shutdown_control_tb;
  import thermal_pkg::*;
  // stimulus and observed signals
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  bus_req_s busReq = '0;
  logic sensorTempOk = 1'b1;
  logic [15:0] readData;
  logic spkL, spkR, pinOne, irqOut;
  logic [3:0] outs;
  logic [15:0] rv;
  int err_total = 0;
  int checks = 0;
  assign outs = {spkL, spkR, pinOne, irqOut};
  thermal_shutdown_control uut (.mclk(mclk), .reset_n(reset_n), .busReq(busReq),
    .readData(readData), .sensorTempOk(sensorTempOk), .speakerLeftOut(spkL),
    .speakerRightOut(spkR), .generalPinOne(pinOne), .irqOut(irqOut));
  // free running clock
  initial begin
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // compare seen against expected
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  // one cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    busReq.wr <= 1'b0;
  endtask
  // read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    busReq <= '{a, ZERO16, 1'b0, 1'b1};
    @(posedge mclk);
    busReq.rd <= 1'b0;
    #1 d = readData;
  endtask
  // let registered outputs settle
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // drive comparator after an edge
  task automatic sense(input logic v);
    @(posedge mclk);
    sensorTempOk <= v;
    settle(4);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reset values, unmapped access
  task automatic reset_values;
    rd(PWR_ONE_ADDR, rv);
    check(rv, PWR_ONE_RST);
    rd(PWR_TWO_ADDR, rv);
    check(rv, 16'h6000);
    rd(IRQ_MASK_ADDR, rv);
    check(rv, 16'h0003);
    wr(8'h30, 16'hffff);
    rd(8'h30, rv);
    check(rv, ZERO16);
    rd(PWR_TWO_ADDR, rv);
    check(rv, PWR_TWO_RST);
    check({12'h000, outs}, 16'h0000);
  endtask
  // armed overheat cuts speakers, events and pin follow
  task automatic overheat_cut;
    wr(PWR_ONE_ADDR, 16'h3000);
    wr(PIN_SEL_ADDR, 16'h0001);
    wr(IRQ_MASK_ADDR, ZERO16);
    settle(2);
    check({12'h000, outs}, 16'h000e);
    sense(1'b0);
    check({12'h000, outs}, 16'h0001);
    rd(IRQ_STAT_ADDR, rv);
    check(rv, 16'h0001);
    wr(PIN_SEL_ADDR, 16'h0002);
    settle(2);
    check({12'h000, outs}, 16'h0003);
    wr(IRQ_MASK_ADDR, 16'h0001);
    settle(2);
    check({12'h000, outs}, 16'h0000);
    wr(IRQ_MASK_ADDR, ZERO16);
    wr(IRQ_STAT_ADDR, 16'h0001);
    settle(2);
    check({12'h000, outs}, 16'h0000);
    sense(1'b1);
    check({12'h000, outs}, 16'h000f);
    rd(IRQ_STAT_ADDR, rv);
    check(rv, 16'h0006);
    wr(IRQ_STAT_ADDR, 16'h0003);
    settle(2);
    check({12'h000, outs}, 16'h000c);
  endtask
  // arm without sensor never cuts; controls change with speakers off
  task automatic arm_alone;
    wr(PWR_ONE_ADDR, ZERO16);
    wr(PWR_TWO_ADDR, 16'h2000);
    wr(PWR_ONE_ADDR, 16'h3000);
    wr(PIN_SEL_ADDR, 16'h0003);
    sense(1'b0);
    check({12'h000, outs}, 16'h000e);
    rd(IRQ_STAT_ADDR, rv);
    check(rv, 16'h0004);
  endtask
  // sensor enabled but not armed: events flow, speakers stay on
  task automatic enable_alone;
    sense(1'b1);
    wr(PWR_ONE_ADDR, ZERO16);
    wr(PWR_TWO_ADDR, 16'h4000);
    wr(PWR_ONE_ADDR, 16'h3000);
    sense(1'b0);
    check({12'h000, outs}, 16'h000f);
    rd(IRQ_STAT_ADDR, rv);
    check(rv, 16'h0001);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic close_out;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    reset_values();
    overheat_cut();
    arm_alone();
    enable_alone();
    close_out();
  end
endmodule
